// >>> hdl/spm_pkg.sv
// Shared constants and carrier types for the priority map register bank
package spm_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_MAP_LOW   = 8'h80;
  localparam logic [7:0] IDX_MAP_HIGH  = 8'h81;
  localparam logic [7:0] IDX_FOLD_CTRL = 8'h82;
  localparam logic [7:0] IDX_UU_FWD    = 8'h83;
  localparam logic [7:0] IDX_GCTL_NEXT = 8'h84;
  localparam logic [7:0] IDX_MODE      = 8'hC0;
  localparam logic [7:0] IDX_STATUS    = 8'hC1;

  // Field layout
  localparam int ENTRY_W     = 2;
  localparam int NUM_PCP     = 8;
  localparam int SPLIT_LSB   = 6;
  localparam int UU_EN_BIT   = 5;
  localparam int NUM_PORTS   = 5;
  localparam int MODE_TWOQ   = 0;
  localparam int RSVD_LSB    = 6;

  // Reset values
  localparam logic [7:0] MAP_LOW_RST  = 8'h50;
  localparam logic [7:0] MAP_HIGH_RST = 8'hFA;
  localparam logic [1:0] SPLIT_RST    = 2'h2;
  localparam logic [5:0] FOLD_RSVD    = 6'h08;
  localparam logic [1:0] UU_RSVD      = 2'h2;
  localparam logic [1:0] NEXT_RSVD    = 2'h1;
  localparam logic [5:0] NEXT_RST     = 6'h00;
  localparam logic       UU_EN_RST    = 1'h0;
  localparam logic [4:0] UU_MASK_RST  = 5'h00;
  localparam logic       TWOQ_RST     = 1'h0;

  // Two-queue split settings
  typedef enum logic [1:0] {
    SPLIT_ONLY_TOP  = 2'h0,
    SPLIT_UNSUP     = 2'h1,
    SPLIT_HALF      = 2'h2,
    SPLIT_ONLY_ZERO = 2'h3
  } spm_split_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] pcp;
    logic       useDs;
    logic [1:0] dsQueue;
  } spm_cls_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] queue;
    logic       high;
  } spm_cls_ans_t;

  typedef struct packed {
    logic                 valid;
    logic                 override;
    logic [NUM_PORTS-1:0] portMask;
  } spm_uu_ans_t;
endpackage

// >>> hdl/spm_queue_classifier.sv
// Frame priority lookup and two-queue fold, one registered stage
`timescale 1ns/1ps
module spm_queue_classifier (
  // Clock and reset
  input  logic                  ref_clk,
  input  logic                  resetn,
  // Configuration
  input  logic [7:0]            mapLow,
  input  logic [7:0]            mapHigh,
  input  logic [1:0]            split,
  input  logic                  twoQueue,
  // Request and answer
  input  spm_pkg::spm_cls_req_t req,
  output spm_pkg::spm_cls_ans_t ans
);
  logic [spm_pkg::ENTRY_W-1:0] entry [spm_pkg::NUM_PCP];
  logic [15:0]                 mapAll;
  logic [1:0]                  queueD;
  logic                        highD;
  spm_pkg::spm_cls_ans_t       ans_q;

  assign mapAll = {mapHigh, mapLow};

  // One entry per priority value
  genvar i;
  generate
    for (i = 0; i < spm_pkg::NUM_PCP; i++)
    begin : g_entry
      assign entry[i] = mapAll[i*spm_pkg::ENTRY_W +: spm_pkg::ENTRY_W];
    end
  endgenerate

  // Diffserv results are folded the same way as tag results
  assign queueD = req.useDs ? req.dsQueue : entry[req.pcp];

  // In two-queue mode result 3 is high, 0 low, 1 and 2 follow the split bits; otherwise all results are low
  always_comb
  begin
    highD = 1'b0;
    if (twoQueue)
    begin
      highD = (queueD == 2'h3) | ((queueD == 2'h1) & split[0])
            | ((queueD == 2'h2) & split[1]);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ans_q <= '0;
    end
    else
    begin
      ans_q.valid <= req.valid;
      if (req.valid)
      begin
        ans_q.queue <= queueD;
        ans_q.high  <= highD;
      end
    end
  end

  assign ans = ans_q;
endmodule

// >>> hdl/spm_priority_map_regs.sv
// Priority map, two-queue fold and unknown unicast forwarding registers on APB
`timescale 1ns/1ps
module spm_priority_map_regs #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  logic                           ref_clk,
  input  logic                           resetn,
  // APB slave
  input  logic                           psel,
  input  logic                           penable,
  input  logic                           pwrite,
  input  logic [ADDR_W-1:0]              paddr,
  input  logic [31:0]                    pwdata,
  input  logic [3:0]                     pstrb,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Frame classification
  input  spm_pkg::spm_cls_req_t          clsReq,
  output spm_pkg::spm_cls_ans_t          clsAns,
  // Unknown unicast destination lookup
  input  logic                           uuReq,
  output spm_pkg::spm_uu_ans_t           uuAns
);
  logic [7:0]                  mapLow_q;
  logic [7:0]                  mapHigh_q;
  logic [1:0]                  split_q;
  logic                        uuEn_q;
  logic [spm_pkg::NUM_PORTS-1:0] uuMask_q;
  logic [5:0]                  next_q;
  logic                        twoQ_q;
  logic [7:0]                  status_q;
  logic [31:0]                 prdata_q;
  spm_pkg::spm_uu_ans_t        uuAns_q;

  localparam logic [spm_pkg::NUM_PORTS-1:0] UU_ZERO = '0;
  logic                        addrOk;
  logic [7:0]                  idx;
  logic                        hit;
  logic [7:0]                  rdByte;
  logic                        wrAcc;
  logic                        rdSetup;
  logic                        wrMapLow;
  logic                        wrMapHigh;
  logic                        wrFold;
  logic                        wrUu;
  logic                        wrNext;
  logic                        wrMode;

  // Bus decode
  assign idx    = paddr[9:2];
  assign addrOk = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);

  always_comb
  begin
    hit    = 1'b1;
    rdByte = 8'h00;
    if (!addrOk)
    begin
      hit = 1'b0;
    end
    else if (idx == spm_pkg::IDX_MAP_LOW)
    begin
      rdByte = mapLow_q;
    end
    else if (idx == spm_pkg::IDX_MAP_HIGH)
    begin
      rdByte = mapHigh_q;
    end
    else if (idx == spm_pkg::IDX_FOLD_CTRL)
    begin
      rdByte = {split_q, spm_pkg::FOLD_RSVD};
    end
    else if (idx == spm_pkg::IDX_UU_FWD)
    begin
      rdByte = {spm_pkg::UU_RSVD, uuEn_q, uuMask_q};
    end
    else if (idx == spm_pkg::IDX_GCTL_NEXT)
    begin
      rdByte = {spm_pkg::NEXT_RSVD, next_q};
    end
    else if (idx == spm_pkg::IDX_MODE)
    begin
      rdByte = {7'h00, twoQ_q};
    end
    else if (idx == spm_pkg::IDX_STATUS)
    begin
      rdByte = status_q;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  // Zero wait states; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign rdSetup = psel & ~penable & ~pwrite;
  // Only the low byte lane carries register data
  assign wrAcc   = psel & penable & pwrite & pready & hit & pstrb[0];

  assign wrMapLow  = wrAcc && (idx == spm_pkg::IDX_MAP_LOW);
  assign wrMapHigh = wrAcc && (idx == spm_pkg::IDX_MAP_HIGH);
  assign wrFold    = wrAcc && (idx == spm_pkg::IDX_FOLD_CTRL);
  assign wrUu      = wrAcc && (idx == spm_pkg::IDX_UU_FWD);
  assign wrNext    = wrAcc && (idx == spm_pkg::IDX_GCTL_NEXT);
  assign wrMode    = wrAcc && (idx == spm_pkg::IDX_MODE);

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (rdSetup)
    begin
      prdata_q <= {24'h00_0000, hit ? rdByte : 8'h00};
    end
  end

  assign prdata = prdata_q;

  // Priority map entries
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      mapLow_q  <= spm_pkg::MAP_LOW_RST;
      mapHigh_q <= spm_pkg::MAP_HIGH_RST;
    end
    else
    begin
      if (wrMapLow)
      begin
        mapLow_q <= pwdata[7:0];
      end
      if (wrMapHigh)
      begin
        mapHigh_q <= pwdata[7:0];
      end
    end
  end

  // Split field; 01 is stored as written, software keeps away from it
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      split_q <= spm_pkg::SPLIT_RST;
    end
    else if (wrFold)
    begin
      split_q <= pwdata[spm_pkg::SPLIT_LSB +: 2];
    end
  end

  // Unknown unicast forwarding control
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      uuEn_q   <= spm_pkg::UU_EN_RST;
      uuMask_q <= spm_pkg::UU_MASK_RST;
    end
    else if (wrUu)
    begin
      uuEn_q   <= pwdata[spm_pkg::UU_EN_BIT];
      uuMask_q <= pwdata[spm_pkg::NUM_PORTS-1:0];
    end
  end

  // Next control register and mode register
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      next_q <= spm_pkg::NEXT_RST;
      twoQ_q <= spm_pkg::TWOQ_RST;
    end
    else
    begin
      if (wrNext)
      begin
        next_q <= pwdata[spm_pkg::RSVD_LSB-1:0];
      end
      if (wrMode)
      begin
        twoQ_q <= pwdata[spm_pkg::MODE_TWOQ];
      end
    end
  end

  // Classifier pipeline
  spm_queue_classifier u_cls (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .mapLow   (mapLow_q),
    .mapHigh  (mapHigh_q),
    .split    (split_q),
    .twoQueue (twoQ_q),
    .req      (clsReq),
    .ans      (clsAns)
  );

  // Unknown unicast answer; disabled means no override, mask forced to zero
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      uuAns_q <= '0;
    end
    else
    begin
      uuAns_q.valid <= uuReq;
      if (uuReq)
      begin
        uuAns_q.override <= uuEn_q;
        uuAns_q.portMask <= uuEn_q ? uuMask_q : UU_ZERO;
      end
    end
  end

  assign uuAns = uuAns_q;

  // Last answers, visible to software for debug
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      status_q <= 8'h00;
    end
    else
    begin
      if (clsAns.valid)
      begin
        status_q[2:0] <= {clsAns.high, clsAns.queue};
      end
      if (uuAns_q.valid)
      begin
        status_q[3] <= uuAns_q.override;
        status_q[4] <= uuAns_q.override && (uuAns_q.portMask == UU_ZERO);
      end
    end
  end

  // Checks
  logic [15:0] chkMap;
  logic [1:0]  chkEntry;

  assign chkMap   = {mapHigh_q, mapLow_q};
  assign chkEntry = chkMap[{clsReq.pcp, 1'b0} +: 2];

  sequence s_release;
    $rose(resetn);
  endsequence

  sequence s_tag_req;
    clsReq.valid && !clsReq.useDs;
  endsequence

  sequence s_split_req(logic [1:0] v);
    clsReq.valid && twoQ_q && (split_q == v);
  endsequence

  property p_map_low_rst;
    @(posedge ref_clk) disable iff (!resetn)
    s_release |-> mapLow_q == spm_pkg::MAP_LOW_RST;
  endproperty
  a_map_low_rst: assert property (p_map_low_rst)
    else $error("first map register reset value wrong");

  property p_map_high_rst;
    @(posedge ref_clk) disable iff (!resetn)
    s_release |-> mapHigh_q == spm_pkg::MAP_HIGH_RST;
  endproperty
  a_map_high_rst: assert property (p_map_high_rst)
    else $error("second map register reset value wrong");

  property p_map_write;
    @(posedge ref_clk) disable iff (!resetn)
    wrMapLow |=> mapLow_q == $past(pwdata[7:0]);
  endproperty
  a_map_write: assert property (p_map_write)
    else $error("map write not stored");

  property p_tag_lookup;
    @(posedge ref_clk) disable iff (!resetn)
    s_tag_req |=> clsAns.valid && (clsAns.queue == $past(chkEntry));
  endproperty
  a_tag_lookup: assert property (p_tag_lookup)
    else $error("tag priority mapped to wrong queue");

  property p_order;
    @(posedge ref_clk) disable iff (!resetn)
    clsAns.valid && $past(twoQ_q) |->
      (clsAns.queue == 2'h3 |-> clsAns.high) and (clsAns.queue == 2'h0 |-> !clsAns.high);
  endproperty
  a_order: assert property (p_order)
    else $error("queue three not high or queue zero not low");

  property p_ds_fold;
    @(posedge ref_clk) disable iff (!resetn)
    clsReq.valid && clsReq.useDs |=> clsAns.queue == $past(clsReq.dsQueue);
  endproperty
  a_ds_fold: assert property (p_ds_fold)
    else $error("diffserv result not passed to fold");

  property p_split_top;
    @(posedge ref_clk) disable iff (!resetn)
    s_split_req(2'h0) |=> clsAns.high == (clsAns.queue == 2'h3);
  endproperty
  a_split_top: assert property (p_split_top)
    else $error("split 00 fold wrong");

  property p_split_half;
    @(posedge ref_clk) disable iff (!resetn)
    s_split_req(2'h2) |=> clsAns.high == clsAns.queue[1];
  endproperty
  a_split_half: assert property (p_split_half)
    else $error("split 10 fold wrong");

  property p_split_zero;
    @(posedge ref_clk) disable iff (!resetn)
    s_split_req(2'h3) |=> clsAns.high == (clsAns.queue != 2'h0);
  endproperty
  a_split_zero: assert property (p_split_zero)
    else $error("split 11 fold wrong");

  property p_split_rst;
    @(posedge ref_clk) disable iff (!resetn)
    s_release |-> split_q == spm_pkg::SPLIT_RST;
  endproperty
  a_split_rst: assert property (p_split_rst)
    else $error("split reset value wrong");

  property p_uu_off;
    @(posedge ref_clk) disable iff (!resetn)
    uuReq && !uuEn_q |=> uuAns.valid && !uuAns.override && (uuAns.portMask == UU_ZERO);
  endproperty
  a_uu_off: assert property (p_uu_off)
    else $error("disabled forwarding still overrides");

  property p_uu_mask;
    @(posedge ref_clk) disable iff (!resetn)
    uuReq && uuEn_q |=> uuAns.override && (uuAns.portMask == $past(uuMask_q));
  endproperty
  a_uu_mask: assert property (p_uu_mask)
    else $error("forward mask not applied");

  property p_uu_rst;
    @(posedge ref_clk) disable iff (!resetn)
    s_release |-> !uuEn_q && (uuMask_q == UU_ZERO);
  endproperty
  a_uu_rst: assert property (p_uu_rst)
    else $error("forwarding control reset value wrong");
endmodule

// >>> tb/spm_priority_map_regs_tb.sv
// Self-checking bench for the priority map register bank
`timescale 1ns/1ps
module spm_priority_map_regs_tb;
  logic                  ref_clk;
  logic                  resetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [3:0]            pstrb;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  spm_pkg::spm_cls_req_t clsReq;
  spm_pkg::spm_cls_ans_t clsAns;
  logic                  uuReq;
  spm_pkg::spm_uu_ans_t  uuAns;
  logic [31:0]           expQ[$];
  logic [31:0]           seed;
  logic [7:0]            mapL;
  logic [7:0]            mapH;
  logic [1:0]            split;
  logic [4:0]            mask;
  int                    n_mismatch;
  int                    checks;

  spm_priority_map_regs #(
    .ADDR_W (12)
  ) dut (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .clsReq  (clsReq),
    .clsAns  (clsAns),
    .uuReq   (uuReq),
    .uuAns   (uuAns)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [1:0] entry(input logic [2:0] p);
    logic [7:0] m;
    m = p[2] ? mapH : mapL;
    return m[2*p[1:0] +: 2];
  endfunction

  function automatic logic fold(input logic [1:0] r, input logic [1:0] s);
    return (r == 2'h3) || (r == 2'h1 && s[0]) || (r == 2'h2 && s[1]);
  endfunction

  function automatic logic [31:0] pop();
    if (expQ.size() == 0)
      return 32'hFFFFFFFF;
    return expQ.pop_front();
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Request held from setup until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] st, input logic [7:0] exp, input logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {seed[31:8], d};
    pstrb   <= st;
    if (!wr)
      expQ.push_back({24'h000000, exp});
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    chk({31'h0, pslverr}, {31'h0, err});
    psel    <= 1'b0;
    penable <= 1'b0;
    seed = lfsr(seed);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'h1, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, 4'hF, exp, 1'b0);
  endtask

  // Unused diffserv input still carries a random value on tag requests
  task automatic cls(input logic [2:0] p, input logic ds, input logic [1:0] r, input logic h);
    @(posedge ref_clk);
    clsReq <= '{1'b1, p, ds, ds ? r : seed[1:0]};
    expQ.push_back({29'h0, r, h});
    @(posedge ref_clk);
    clsReq.valid <= 1'b0;
    seed = lfsr(seed);
  endtask

  task automatic uu(input logic ov, input logic [4:0] m);
    @(posedge ref_clk);
    uuReq <= 1'b1;
    expQ.push_back({26'h0, ov, m});
    @(posedge ref_clk);
    uuReq <= 1'b0;
  endtask

  always @(posedge ref_clk)
  begin
    if (resetn === 1'b1 && psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
        pwrite === 1'b0)
      chk(prdata, pop());
    if (clsAns.valid === 1'b1)
      chk({29'h0, clsAns.queue, clsAns.high}, pop());
    if (uuAns.valid === 1'b1)
      chk({26'h0, uuAns.override, uuAns.portMask}, pop());
  end

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Whole run needs well under a tenth of this
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    resetn     = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h00000000;
    pstrb      = 4'h0;
    clsReq     = '0;
    uuReq      = 1'b0;
    seed       = 32'h00012BEA;
    n_mismatch = 0;
    checks     = 0;
    mapL       = 8'h50;
    mapH       = 8'hFA;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(12'h200, 8'h50);
    rd(12'h204, 8'hFA);
    rd(12'h208, 8'h88);
    rd(12'h20C, 8'h80);
    rd(12'h210, 8'h40);
    rd(12'h300, 8'h00);
    uu(1'b0, 5'h00);
    for (int p = 0; p < 8; p++)
      cls(p[2:0], 1'b0, entry(p[2:0]), 1'b0);
    mapL = seed[7:0];
    mapH = seed[15:8];
    wr(12'h200, mapL);
    wr(12'h204, mapH);
    apb(1'b1, 12'h200, ~mapL, 4'hE, 8'h00, 1'b0);
    rd(12'h200, mapL);
    rd(12'h204, mapH);
    for (int p = 0; p < 8; p++)
      cls(p[2:0], 1'b0, entry(p[2:0]), 1'b0);
    wr(12'h300, 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      if (s == 1)
        continue; // Unsupported split never programmed
      split = s[1:0];
      wr(12'h208, {split, 6'h3F});
      rd(12'h208, {split, 6'h08});
      for (int r = 0; r < 4; r++)
        cls(3'h0, 1'b1, r[1:0], fold(r[1:0], split));
      for (int p = 0; p < 8; p++)
        cls(p[2:0], 1'b0, entry(p[2:0]), fold(entry(p[2:0]), split));
    end
    wr(12'h300, 8'h00);
    cls(3'h0, 1'b1, 2'h3, 1'b0);
    wr(12'h20C, 8'h20);
    uu(1'b1, 5'h00);
    rd(12'h304, 8'h1B);
    wr(12'h20C, 8'h3F);
    uu(1'b1, 5'h1F);
    mask = seed[4:0];
    wr(12'h20C, {3'b001, mask});
    rd(12'h20C, {3'b101, mask});
    uu(1'b1, mask);
    wr(12'h20C, 8'hDF);
    rd(12'h20C, 8'h9F);
    uu(1'b0, 5'h00);
    wr(12'h210, 8'hFF);
    rd(12'h210, 8'h7F);
    apb(1'b1, 12'h3F0, 8'hFF, 4'hF, 8'h00, 1'b1);
    apb(1'b0, 12'h3F0, 8'h00, 4'hF, 8'h00, 1'b1);
    apb(1'b0, 12'h201, 8'h00, 4'hF, 8'h00, 1'b1);
    // Second reset in mid-run must restore the defaults
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    mapL = 8'h50;
    mapH = 8'hFA;
    rd(12'h200, 8'h50);
    rd(12'h20C, 8'h80);
    cls(3'h5, 1'b0, entry(3'h5), 1'b0);
    repeat (4) @(posedge ref_clk);
    chk(32'(expQ.size()), 32'h00000000);
    end_of_test();
  end
endmodule
